// ===== hdl/ext_irq_pkg.sv
// Constants shared by the external edge interrupt and flag unit
package ext_irq_pkg;
  // Register addresses on the special-function register port
  localparam logic [7:0] ADDR_PIN_CONFIG = 8'hb7;
  localparam logic [7:0] ADDR_FLAGS      = 8'hbf;

  // Reset values
  localparam logic [7:0] PIN_CONFIG_RESET = 8'h00;
  localparam logic [4:0] FLAGS_RESET      = 5'h00;
  localparam logic [7:0] RDATA_RESET      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;

  // Pin configuration field positions
  localparam int SRC_B_POLARITY_BIT = 7;
  localparam int SRC_B_SEL_HI       = 6;
  localparam int SRC_B_SEL_LO       = 4;
  localparam int SRC_A_POLARITY_BIT = 3;
  localparam int SRC_A_SEL_HI       = 2;
  localparam int SRC_A_SEL_LO       = 0;

  // Flag register bit positions
  localparam int FLAG_W              = 5;
  localparam int SPARE_B_BIT         = 4;
  localparam int SPARE_A_BIT         = 3;
  localparam int TX_EMPTY_BIT        = 2;
  localparam int EXT_B_PENDING_BIT   = 1;
  localparam int EXT_A_PENDING_BIT   = 0;
  localparam logic [2:0] RSVD_READ   = 3'h0;

  // Pin select decoding
  localparam int              GPIO_W        = 10;
  localparam int              PIN_IDX_W     = 4;
  localparam logic [2:0]      SEL_ALT_CODE  = 3'h5;
  localparam logic [3:0]      SRC_A_ALT_PIN = 4'h8;
  localparam logic [3:0]      SRC_B_ALT_PIN = 4'h9;
endpackage

// ===== hdl/edge_event_detect.sv
// Polarity stage and single or double edge detector for one source
module edge_event_detect (
  input  wire logic sys_clk,        // System clock
  input  wire logic reset,          // Synchronous reset, active high
  input  wire logic clk_en,         // Freezes all state while low
  input  wire logic pin_level,      // Filtered level of selected pin
  input  wire logic pass_unchanged, // 1 passes pin, 0 inverts it
  input  wire logic double_edge,    // 1 detects both edges
  output logic      edge_event      // Registered edge event
);
  logic polar;
  logic prev;
  logic primed;
  logic next_prev;
  logic next_primed;
  logic next_event;

  assign polar = pass_unchanged ? pin_level : ~pin_level;

  always_comb begin
    next_prev   = prev;
    next_primed = primed;
    next_event  = edge_event;
    if (clk_en) begin
      // Previous sample kept so two clock samples can be compared
      next_prev   = polar;
      next_primed = 1'b1;
      // First sample after reset only arms: a level is never an edge
      if (!primed) begin
        next_event = 1'b0;
      end else if (double_edge) begin
        next_event = polar ^ prev;
      end else begin
        next_event = polar & ~prev;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prev       <= 1'b0;
      primed     <= 1'b0;
      edge_event <= 1'b0;
    end else begin
      prev       <= next_prev;
      primed     <= next_primed;
      edge_event <= next_event;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_armed;
    clk_en && primed;
  endsequence

  sequence s_pin_fall_inverted;
    !pass_unchanged && !pin_level && !prev;
  endsequence

  AST_STEADY_NO_EVENT: assert property (
    (clk_en && polar == prev) |=> !edge_event)
    else $error("steady level produced an edge event");

  AST_RISE_EVENT: assert property (
    s_armed ##0 (polar && !prev) |=> edge_event)
    else $error("rising edge missed");

  AST_FALL_SINGLE_IGNORED: assert property (
    (clk_en && !double_edge && !polar && prev) |=> !edge_event)
    else $error("falling edge seen in single edge mode");

  AST_FALL_DOUBLE_EVENT: assert property (
    s_armed ##0 (double_edge && !polar && prev) |=> edge_event)
    else $error("falling edge missed in double edge mode");

  AST_INVERT_FALL: assert property (
    s_armed ##0 s_pin_fall_inverted |=> edge_event)
    else $error("inverted pin fall did not give an event");
endmodule

// ===== hdl/ext_edge_irq_flags.sv
// External edge interrupt sources and shared interrupt flag register

// Behaviour
// - Flag register bits 7:5 read zero; writes to them do nothing.
// - Spare flags 4 and 3 set only by software writing one; request irq.
// - Flag 2 sets when serializer transmit holding register empties.
// - Flags 1 and 0 set by selected edges, regardless of enable bits.
// - External pending flags stay set; only a software write clears them.
// - Steady pin levels set no external flag unless a config write flips the polarity or selected pin.
// - Each source triggers on rising, falling or both edges.
// - Polarity bit 0 inverts the selected pin; 1 passes it unchanged.
// - After polarity, detect rising only or both edges per mode bit.
// - Bits 6:4 pick source B pin; code 101 picks input 9.
// - Bits 2:0 pick source A pin; code 101 picks input 8.
// - Pins sampled by system clock; pulses under two clocks may be lost.
// - Detection works at any system clock rate, down to slowest.
// - Source B event drives timer 3 capture, source A timer 2.
module ext_edge_irq_flags #(
  parameter int GPIO_W = ext_irq_pkg::GPIO_W
) (
  input  wire logic              sys_clk,    // System clock
  input  wire logic              reset,      // Synchronous reset, high
  input  wire logic              clk_en,     // Freezes state while low
  input  wire logic [7:0]        sfr_addr,   // Register address
  input  wire logic              sfr_wr,     // Write strobe
  input  wire logic              sfr_rd,     // Read strobe
  input  wire logic [7:0]        sfr_wdata,  // Write data
  output logic      [7:0]        sfr_rdata,  // Read data, next cycle
  input  wire logic [GPIO_W-1:0] gpio_in,    // Asynchronous pin inputs
  input  wire logic              ext_src_a_double_edge, // A both edges
  input  wire logic              ext_src_b_double_edge, // B both edges
  input  wire logic [4:0]        irq_enable, // Per flag enables
  input  wire logic              tx_empty_event, // Holding reg emptied
  output logic      [4:0]        irq_req,    // Per flag requests
  output logic                   timer2_capture, // Source A event
  output logic                   timer3_capture  // Source B event
);
  localparam int FW = ext_irq_pkg::FLAG_W;

  // Register state
  logic [7:0]        ext_irq_pin_config;
  logic [FW-1:0]     irq_flag_status;
  logic [7:0]        next_pin_config;
  logic [FW-1:0]     next_flags;
  logic [7:0]        next_rdata;

  // Pin synchronisers and agreement filter
  logic [GPIO_W-1:0] sync1;
  logic [GPIO_W-1:0] sync2;
  logic [GPIO_W-1:0] sync3;
  logic [GPIO_W-1:0] pin_filt;
  logic [GPIO_W-1:0] next_pin_filt;
  logic [3:0]        pin_fill;
  logic [3:0]        next_pin_fill;
  logic              detect_reset;

  // Per source wiring
  logic [2:0]        src_sel [2];
  logic [1:0]        src_pass;
  logic [1:0]        src_double;
  logic [1:0]        src_level;
  logic [1:0]        ext_event;
  logic              wr_config;
  logic              wr_flags;
  logic [FW-1:0]     hw_set;
  logic [FW-1:0]     sw_value;

  // Both sources share this decode; only code 101 differs
  function automatic logic [ext_irq_pkg::PIN_IDX_W-1:0] select_pin(
    input logic [2:0]                          code,
    input logic [ext_irq_pkg::PIN_IDX_W-1:0]   alt_pin
  );
    logic [ext_irq_pkg::PIN_IDX_W-1:0] idx;
    idx = {1'b0, code};
    if (code == ext_irq_pkg::SEL_ALT_CODE) begin
      idx = alt_pin;
    end
    return idx;
  endfunction

  // Synchroniser chain; stage one feeds stage two only
  always_comb begin
    next_pin_filt = pin_filt;
    next_pin_fill = pin_fill;
    if (clk_en) begin
      // A change counts once stages two and three agree
      next_pin_filt = (sync2 & sync3) | (pin_filt & (sync2 | sync3));
      // One bit per stage of the pin path, filled after reset
      next_pin_fill = {pin_fill[2:0], 1'b1};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync1    <= '0;
      sync2    <= '0;
      sync3    <= '0;
      pin_filt <= '0;
      pin_fill <= '0;
    end else if (clk_en) begin
      sync1    <= gpio_in;
      sync2    <= sync1;
      sync3    <= sync2;
      pin_filt <= next_pin_filt;
      pin_fill <= next_pin_fill;
    end
  end

  // Detectors stay in reset until the pin path holds real samples;
  // otherwise a pin held high through reset reads as a fresh edge
  assign detect_reset = reset | ~pin_fill[3];

  // Configuration fields per source
  assign src_sel[0] = ext_irq_pin_config[ext_irq_pkg::SRC_A_SEL_HI:
                                         ext_irq_pkg::SRC_A_SEL_LO];
  assign src_sel[1] = ext_irq_pin_config[ext_irq_pkg::SRC_B_SEL_HI:
                                         ext_irq_pkg::SRC_B_SEL_LO];
  assign src_pass[0] =
    ext_irq_pin_config[ext_irq_pkg::SRC_A_POLARITY_BIT];
  assign src_pass[1] =
    ext_irq_pin_config[ext_irq_pkg::SRC_B_POLARITY_BIT];
  assign src_double = {ext_src_b_double_edge, ext_src_a_double_edge};

  // Sampling only, no fixed time constants, so any clock rate works
  generate
    for (genvar i = 0; i < 2; i++) begin : g_src
      localparam logic [ext_irq_pkg::PIN_IDX_W-1:0] ALT_PIN =
        (i == 0) ? ext_irq_pkg::SRC_A_ALT_PIN : ext_irq_pkg::SRC_B_ALT_PIN;

      assign src_level[i] =
        pin_filt[select_pin(src_sel[i], ALT_PIN)];

      edge_event_detect u_detect (
        .sys_clk        (sys_clk),
        .reset          (detect_reset),
        .clk_en         (clk_en),
        .pin_level      (src_level[i]),
        .pass_unchanged (src_pass[i]),
        .double_edge    (src_double[i]),
        .edge_event     (ext_event[i])
      );
    end
  endgenerate

  assign timer2_capture = ext_event[0];
  assign timer3_capture = ext_event[1];

  // Register port decode
  assign wr_config = sfr_wr && (sfr_addr == ext_irq_pkg::ADDR_PIN_CONFIG);
  assign wr_flags  = sfr_wr && (sfr_addr == ext_irq_pkg::ADDR_FLAGS);
  assign sw_value  = sfr_wdata[FW-1:0];

  // Spare flags have no hardware source at all
  always_comb begin
    hw_set = '0;
    hw_set[ext_irq_pkg::TX_EMPTY_BIT]      = tx_empty_event;
    hw_set[ext_irq_pkg::EXT_B_PENDING_BIT] = ext_event[1];
    hw_set[ext_irq_pkg::EXT_A_PENDING_BIT] = ext_event[0];
  end

  always_comb begin
    next_pin_config = ext_irq_pin_config;
    next_flags      = irq_flag_status;
    next_rdata      = sfr_rdata;
    if (clk_en) begin
      if (wr_config) begin
        next_pin_config = sfr_wdata;
      end
      // Hardware never clears; a set in the clearing cycle wins
      if (wr_flags) begin
        next_flags = sw_value | hw_set;
      end else begin
        next_flags = irq_flag_status | hw_set;
      end
      if (sfr_rd) begin
        case (sfr_addr)
          ext_irq_pkg::ADDR_PIN_CONFIG: next_rdata = ext_irq_pin_config;
          ext_irq_pkg::ADDR_FLAGS:
            next_rdata = {ext_irq_pkg::RSVD_READ, irq_flag_status};
          default: next_rdata = ext_irq_pkg::UNMAPPED_READ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_irq_pin_config <= ext_irq_pkg::PIN_CONFIG_RESET;
      irq_flag_status    <= ext_irq_pkg::FLAGS_RESET;
      sfr_rdata          <= ext_irq_pkg::RDATA_RESET;
    end else begin
      ext_irq_pin_config <= next_pin_config;
      irq_flag_status    <= next_flags;
      sfr_rdata          <= next_rdata;
    end
  end

  // Request is a level; the core decides when to service it
  assign irq_req = irq_flag_status & irq_enable;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_wr_flags;
    clk_en && wr_flags;
  endsequence

  sequence s_no_flag_write;
    clk_en && !wr_flags;
  endsequence

  sequence s_flag_read;
    clk_en && sfr_rd && sfr_addr == ext_irq_pkg::ADDR_FLAGS;
  endsequence

  // Only a flag read is checked: a config read may show any top bits
  AST_RSVD_ZERO: assert property (
    s_flag_read |=> sfr_rdata[7:5] == 3'h0)
    else $error("reserved flag bits read nonzero");

  AST_FLAG_READBACK: assert property (
    s_flag_read |=> sfr_rdata[FW-1:0] == $past(irq_flag_status))
    else $error("flag read returned a wrong value");

  AST_SPARE_SET: assert property (
    s_wr_flags ##0 sfr_wdata[ext_irq_pkg::SPARE_B_BIT]
    |=> irq_flag_status[ext_irq_pkg::SPARE_B_BIT])
    else $error("spare flag not set by software");

  AST_SPARE_NO_HW: assert property (
    s_no_flag_write ##0 !irq_flag_status[ext_irq_pkg::SPARE_A_BIT]
    |=> !irq_flag_status[ext_irq_pkg::SPARE_A_BIT])
    else $error("spare flag set without a write");

  AST_TX_EMPTY_SET: assert property (
    (clk_en && tx_empty_event)
    |=> irq_flag_status[ext_irq_pkg::TX_EMPTY_BIT])
    else $error("transmit empty flag not set");

  AST_HW_NEVER_CLEARS: assert property (
    s_no_flag_write
    |=> ((irq_flag_status[2:0] & $past(irq_flag_status[2:0]))
         == $past(irq_flag_status[2:0])))
    else $error("flag cleared without a software write");

  AST_EXT_A_SET: assert property (
    (clk_en && ext_event[0])
    |=> irq_flag_status[ext_irq_pkg::EXT_A_PENDING_BIT])
    else $error("source A event did not set its flag");

  AST_CAPTURE_B: assert property (
    (clk_en && timer3_capture)
    |=> irq_flag_status[ext_irq_pkg::EXT_B_PENDING_BIT])
    else $error("timer 3 capture without source B flag");

  AST_IRQ_FROM_EVENT: assert property (
    (clk_en && tx_empty_event) ##1 irq_enable[2] |-> irq_req[2])
    else $error("enabled flag gave no request");

  AST_SYNC_AGREE: assert property (
    (clk_en && sync2 == sync3) |=> pin_filt == $past(sync3))
    else $error("filter ignored agreeing samples");

  AST_SYNC_HOLD: assert property (
    clk_en |=> ((pin_filt ^ $past(pin_filt)) & $past(sync2 ^ sync3)) == '0)
    else $error("filter moved on disagreeing samples");

  AST_SPARE_A_SET: assert property (
    s_wr_flags ##0 sfr_wdata[ext_irq_pkg::SPARE_A_BIT]
    |=> irq_flag_status[ext_irq_pkg::SPARE_A_BIT])
    else $error("spare flag A not set by software");

  AST_SPARE_B_NO_HW: assert property (
    s_no_flag_write ##0 !irq_flag_status[ext_irq_pkg::SPARE_B_BIT]
    |=> !irq_flag_status[ext_irq_pkg::SPARE_B_BIT])
    else $error("spare flag B set without a write");

  AST_EXT_B_SET: assert property (
    (clk_en && ext_event[1])
    |=> irq_flag_status[ext_irq_pkg::EXT_B_PENDING_BIT])
    else $error("source B event did not set its flag");

  AST_WRITE_CLEARS: assert property (
    s_wr_flags ##0 (sfr_wdata[FW-1:0] == '0 && hw_set == '0)
    |=> irq_flag_status == '0)
    else $error("writing zero did not clear the flags");

  AST_CONFIG_WRITE: assert property (
    (clk_en && wr_config) |=> ext_irq_pin_config == $past(sfr_wdata))
    else $error("pin configuration write lost");

  AST_ALT_PIN_A: assert property (
    (src_sel[0] == ext_irq_pkg::SEL_ALT_CODE)
    |-> src_level[0] == pin_filt[ext_irq_pkg::SRC_A_ALT_PIN])
    else $error("source A alternate pin not selected");

  AST_ALT_PIN_B: assert property (
    (src_sel[1] == ext_irq_pkg::SEL_ALT_CODE)
    |-> src_level[1] == pin_filt[ext_irq_pkg::SRC_B_ALT_PIN])
    else $error("source B alternate pin not selected");

  AST_NO_EVENT_FILLING: assert property (
    !pin_fill[3] |-> ext_event == 2'b00)
    else $error("event before the pin path was filled");

  AST_FROZEN: assert property (
    !clk_en |=> $stable(irq_flag_status) && $stable(ext_irq_pin_config))
    else $error("state moved while the clock enable was low");
endmodule

// ===== sim/pin_model.sv
// Model of the pins and the serializer at the block's far side
module pin_model (
  input  wire logic       sys_clk,        // System clock
  output logic      [9:0] gpio_in,        // Pin levels
  output logic            tx_empty_event  // Holding register emptied
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    gpio_in        = 10'h000;
    tx_empty_event = 1'b0;
  end
  // Levels stay put until the next call, well over two clock periods
  task automatic set_pin(input int idx, input logic level);
    @(negedge sys_clk);
    gpio_in[idx] = level;
  endtask
  task automatic tx_pulse();
    @(negedge sys_clk);
    tx_empty_event = 1'b1;
    @(negedge sys_clk);
    tx_empty_event = 1'b0;
  endtask
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the external edge interrupt and flag unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 1'b0;
  logic       reset, clk_en, sfr_wr, sfr_rd, dbl_a, dbl_b;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
  logic [9:0] gpio_in;
  logic [4:0] irq_enable, irq_req;
  logic       tx_empty_event, timer2_capture, timer3_capture;
  int         n_fail, n_compared, cap_a, cap_b, ca0, cb0;
  localparam logic [7:0] CFG = ext_irq_pkg::ADDR_PIN_CONFIG;
  localparam logic [7:0] FLG = ext_irq_pkg::ADDR_FLAGS;

  pin_model u_pins (
    .sys_clk        (sys_clk),
    .gpio_in        (gpio_in),
    .tx_empty_event (tx_empty_event)
  );
  ext_edge_irq_flags u_dut (
    .sys_clk               (sys_clk),
    .reset                 (reset),
    .clk_en                (clk_en),
    .sfr_addr              (sfr_addr),
    .sfr_wr                (sfr_wr),
    .sfr_rd                (sfr_rd),
    .sfr_wdata             (sfr_wdata),
    .sfr_rdata             (sfr_rdata),
    .gpio_in               (gpio_in),
    .ext_src_a_double_edge (dbl_a),
    .ext_src_b_double_edge (dbl_b),
    .irq_enable            (irq_enable),
    .tx_empty_event        (tx_empty_event),
    .irq_req               (irq_req),
    .timer2_capture        (timer2_capture),
    .timer3_capture        (timer3_capture)
  );

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (timer2_capture) cap_a <= cap_a + 1;
    if (timer3_capture) cap_b <= cap_b + 1;
  end

  task automatic chk(input string what, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    sfr_addr  = a;
    sfr_wdata = v;
    sfr_wr    = 1'b1;
    @(negedge sys_clk);
    sfr_wr    = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge sys_clk);
    sfr_rd   = 1'b0;
    v        = sfr_rdata;
  endtask
  // Synchroniser, filter and event register need about six edges
  task automatic settle();
    repeat (10) @(negedge sys_clk);
  endtask

  task automatic t_reset();
    rd(CFG, d); chk("cfg reset", d, 8'h00);
    rd(FLG, d); chk("flag reset", d, 8'h00);
    rd(8'h00, d); chk("unmapped", d, 8'h00);
  endtask
  task automatic t_flags();
    wr(FLG, 8'hff); rd(FLG, d); chk("top bits", d, 8'h1f);
    chk("req all", {3'h0, irq_req}, 8'h1f);
    wr(FLG, 8'he0); rd(FLG, d); chk("clear", d, 8'h00);
    wr(FLG, 8'h18); rd(FLG, d); chk("spares", d, 8'h18);
    chk("spare req", {3'h0, irq_req}, 8'h18);
    wr(FLG, 8'h00);
  endtask
  task automatic t_select();
    int pa, pb;
    for (int c = 0; c < 8; c++) begin
      pa = (c == 5) ? 8 : c;
      pb = (c == 5) ? 9 : c;
      wr(CFG, {1'b1, 3'(c), 1'b1, 3'(c)});
      settle();
      rd(CFG, d); chk("cfg", d, {1'b1, 3'(c), 1'b1, 3'(c)});
      wr(FLG, 8'h00);
      ca0 = cap_a;
      cb0 = cap_b;
      u_pins.set_pin(pa, 1'b1);
      settle();
      rd(FLG, d); chk("sel a", d, (pa == pb) ? 8'h03 : 8'h01);
      u_pins.set_pin(pb, 1'b1);
      settle();
      rd(FLG, d); chk("sel b", d, 8'h03);
      chk("cap a", 8'(cap_a - ca0), 8'h01);
      chk("cap b", 8'(cap_b - cb0), 8'h01);
      u_pins.set_pin(pa, 1'b0);
      u_pins.set_pin(pb, 1'b0);
      settle();
      rd(FLG, d); chk("sticky", d, 8'h03);
    end
  endtask
  task automatic t_edges();
    wr(CFG, 8'ha1);
    settle();
    wr(FLG, 8'h00);
    u_pins.set_pin(1, 1'b1);
    repeat (3) settle();
    rd(FLG, d); chk("inv fall", d, 8'h00);
    irq_enable = 5'h1e;
    u_pins.set_pin(1, 1'b0);
    settle();
    rd(FLG, d); chk("inv rise", d, 8'h01);
    chk("masked", {3'h0, irq_req}, 8'h00);
    irq_enable = 5'h1f;
    #1 chk("unmasked", {3'h0, irq_req}, 8'h01);
    {dbl_a, dbl_b} = 2'b11;
    // A inverted and B straight: each pin change is an edge for both
    for (int k = 0; k < 2; k++) begin
      wr(FLG, 8'h00);
      u_pins.set_pin(1, k == 0);
      u_pins.set_pin(2, k == 0);
      settle();
      rd(FLG, d); chk("double", d, 8'h03);
    end
    {dbl_a, dbl_b} = 2'b00;
  endtask
  task automatic t_tx();
    wr(FLG, 8'h00);
    u_pins.tx_pulse();
    settle();
    rd(FLG, d); chk("tx set", d, 8'h04);
    settle();
    rd(FLG, d); chk("tx held", d, 8'h04);
    wr(FLG, 8'h00); // Cleared ahead of the next byte
    u_pins.tx_pulse();
    settle();
    rd(FLG, d); chk("tx again", d, 8'h04);
    // Clear and hardware set in one cycle: the set must win
    fork
      wr(FLG, 8'h00);
      u_pins.tx_pulse();
    join
    rd(FLG, d); chk("set wins", d, 8'h04);
    wr(FLG, 8'h00);
    clk_en = 1'b0;
    wr(FLG, 8'h08);
    clk_en = 1'b1;
    rd(FLG, d); chk("frozen", d, 8'h00);
  endtask

  // Pin held high through a mid-run reset must not read as an edge
  task automatic t_rst_pin();
    ca0 = cap_a;
    cb0 = cap_b;
    u_pins.set_pin(0, 1'b1);
    {dbl_a, dbl_b} = 2'b11;
    reset = 1'b1;
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    settle();
    rd(CFG, d); chk("cfg rst", d, 8'h00);
    rd(FLG, d); chk("rst pin high", d, 8'h00);
    chk("cap rst", 8'(cap_a - ca0 + cap_b - cb0), 8'h00);
    {dbl_a, dbl_b} = 2'b00;
    u_pins.set_pin(0, 1'b0);
    settle();
    rd(FLG, d); chk("inv rise ab", d, 8'h03);
    wr(FLG, 8'h00);
    u_pins.set_pin(0, 1'b1);
    settle();
    rd(FLG, d); chk("fall ignored", d, 8'h00);
  endtask

  task automatic summarize();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    summarize();
  end
  initial begin
    {n_fail, n_compared, cap_a, cap_b} = '0;
    {reset, clk_en, sfr_wr, sfr_rd, dbl_a, dbl_b} = 6'b110000;
    {sfr_addr, sfr_wdata, irq_enable} = '0;
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    irq_enable = 5'h1f;
    t_reset();
    t_flags();
    t_select();
    t_edges();
    t_tx();
    t_rst_pin();
    summarize();
  end
endmodule
